// file: freq_ref_pkg.sv
// Notes on behaviour
// R1 - Codes 10 and 11 select raise, lower
// R2 - Lone raise or lower flags config error
// R3 - Raise/lower with ramp hold flags error
// R4 - Output ramps to reference at set rates
// R5 - Operator picks terminal run source setting 1
// R6 - Upper limit 0.0..110.0, default 100.0%
// R7 - Lower limit held, default 0.0%
// R8 - Master lower limit held, default 0.0%
// R9 - Analog input is floor; larger wins
// R10 - Run start accelerates to effective floor
// R11 - Multi-step disabled while raise/lower used
// R12 - Memory 1 keeps reference across power loss
// R13 - Raise/lower on at run clears store
// R14 - Codes 1C and 1D select trim inputs
// R15 - Trim level 0..100, default 10%
// R16 - One trim input adds/subtracts, else unmodified
// R17 - Trim only for analog reference above 0
// R18 - Negative trimmed result forces zero reference
// R19 - Lone trim input flags config error
// R20 - Match flag when running and not ramping
// R21 - Memory 0 restarts from zero reference
// R22 - Raise alone up, lower alone down, else hold
package freq_ref_pkg;

  // ----------------------------------------
  // Terminal functions
  // ----------------------------------------
  localparam int NUM_TERMINALS = 10;
  localparam logic [7:0] FUNC_RAMP_HOLD = 8'h0a;
  localparam logic [7:0] FUNC_UP = 8'h10;
  localparam logic [7:0] FUNC_DOWN = 8'h11;
  localparam logic [7:0] FUNC_TRIM_INC = 8'h1c;
  localparam logic [7:0] FUNC_TRIM_DEC = 8'h1d;
  localparam logic [1:0] RUN_SOURCE_TERMINALS = 2'h1;

  // ----------------------------------------
  // Frequency units: 0.1 % of maximum output frequency
  // ----------------------------------------
  localparam int FREQ_W = 12;
  localparam logic [11:0] FREQ_ZERO = 12'h000;
  localparam logic [11:0] LIMIT_MAX = 12'h044c;
  localparam logic [11:0] DEF_UPPER_LIMIT = 12'h03e8;
  localparam logic [11:0] DEF_LOWER_LIMIT = 12'h000;
  localparam logic [11:0] DEF_MASTER_LOWER_LIMIT = 12'h000;
  localparam logic [6:0] DEF_TRIM_LEVEL = 7'h0a;
  localparam logic [6:0] TRIM_LEVEL_MAX = 7'h64;
  localparam logic [11:0] TRIM_SCALE = 12'h00a;
  localparam logic [11:0] FREQ_STEP = 12'h001;
  localparam logic [15:0] RATE_CNT_ZERO = 16'h0000;
  localparam logic [15:0] RATE_CNT_ONE = 16'h0001;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [FREQ_W-1:0] freq_type;
  typedef logic [NUM_TERMINALS-1:0][7:0] func_sel_type;

  typedef struct packed {
    freq_type reference_upper_limit_pct;
    freq_type reference_lower_limit_pct;
    freq_type master_reference_lower_limit_pct;
    logic [6:0] trim_level_pct;
    logic reference_hold_memory_select;
    logic [15:0] accel_step_cycles;
    logic [15:0] decel_step_cycles;
  } cfg_type;

  typedef enum logic [1:0] {st_stop, st_accel, st_decel, st_match} ramp_state_type;

endpackage

// file: freq_ref_up_down_trim.sv
`timescale 1ns/100ps
module freq_ref_up_down_trim (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Terminal functions and levels
  input wire freq_ref_pkg::func_sel_type i_input_function_select,
  input wire logic [freq_ref_pkg::NUM_TERMINALS-1:0] i_multi_input_terminal,
  // Run command and reference
  input wire logic i_run,
  input wire logic i_ref_from_analog,
  input wire freq_ref_pkg::freq_type i_analog_reference_input,
  input wire freq_ref_pkg::cfg_type i_cfg,
  // Retained reference
  input wire freq_ref_pkg::freq_type i_retained_ref,
  output freq_ref_pkg::freq_type o_stored_ref,
  // Outputs and status
  output freq_ref_pkg::freq_type o_out_freq,
  output logic o_freq_match,
  output logic o_input_config_error,
  output logic o_multi_step_enable
);

  // ----------------------------------------
  // Terminal decode
  // ----------------------------------------
  logic [freq_ref_pkg::NUM_TERMINALS-1:0] hit_up;
  logic [freq_ref_pkg::NUM_TERMINALS-1:0] hit_dn;
  logic [freq_ref_pkg::NUM_TERMINALS-1:0] hit_hold;
  logic [freq_ref_pkg::NUM_TERMINALS-1:0] hit_tinc;
  logic [freq_ref_pkg::NUM_TERMINALS-1:0] hit_tdec;

  // Per-terminal function match
  for (genvar g = 0; g < freq_ref_pkg::NUM_TERMINALS; g++) begin : g_term
    assign hit_up[g] = (i_input_function_select[g] == freq_ref_pkg::FUNC_UP); // R1
    assign hit_dn[g] = (i_input_function_select[g] == freq_ref_pkg::FUNC_DOWN); // R1
    assign hit_hold[g] = (i_input_function_select[g] == freq_ref_pkg::FUNC_RAMP_HOLD);
    assign hit_tinc[g] = (i_input_function_select[g] == freq_ref_pkg::FUNC_TRIM_INC); // R14
    assign hit_tdec[g] = (i_input_function_select[g] == freq_ref_pkg::FUNC_TRIM_DEC); // R14
  end

  logic up_asg;
  logic dn_asg;
  logic hold_asg;
  logic tinc_asg;
  logic tdec_asg;
  logic up_on;
  logic dn_on;
  logic tinc_on;
  logic tdec_on;
  logic next_cfg_err;
  logic updown_mode;
  logic trim_mode;

  // Assignment summary and active levels
  assign up_asg = |hit_up;
  assign dn_asg = |hit_dn;
  assign hold_asg = |hit_hold;
  assign tinc_asg = |hit_tinc;
  assign tdec_asg = |hit_tdec;
  assign up_on = |(hit_up & i_multi_input_terminal);
  assign dn_on = |(hit_dn & i_multi_input_terminal);
  assign tinc_on = |(hit_tinc & i_multi_input_terminal);
  assign tdec_on = |(hit_tdec & i_multi_input_terminal);

  // Invalid assignment combinations
  assign next_cfg_err = (up_asg ^ dn_asg) // R2
    | ((up_asg | dn_asg) & hold_asg) // R3
    | (tinc_asg ^ tdec_asg); // R19
  assign updown_mode = up_asg & dn_asg & ~next_cfg_err;
  assign trim_mode = tinc_asg & tdec_asg & ~next_cfg_err;

  // ----------------------------------------
  // Limits
  // ----------------------------------------
  freq_ref_pkg::freq_type upper_lim;
  freq_ref_pkg::freq_type cfg_lower;
  freq_ref_pkg::freq_type eff_lower;

  // Upper limit clipped to its settable range
  // Larger settings act as the top of the range
  always_comb begin
    upper_lim = i_cfg.reference_upper_limit_pct; // R6
    if (upper_lim > freq_ref_pkg::LIMIT_MAX) begin
      upper_lim = freq_ref_pkg::LIMIT_MAX; // R6
    end
  end

  // Effective floor is the largest of the lower limits
  // A floor above the ceiling is pulled down so the two never cross
  always_comb begin
    cfg_lower = i_cfg.reference_lower_limit_pct; // R7
    if (i_cfg.master_reference_lower_limit_pct > cfg_lower) begin
      cfg_lower = i_cfg.master_reference_lower_limit_pct; // R8
    end
    eff_lower = cfg_lower;
    if (updown_mode && (i_analog_reference_input > eff_lower)) begin
      eff_lower = i_analog_reference_input; // R9
    end
    if (eff_lower > upper_lim) begin
      eff_lower = upper_lim;
    end
  end

  // ----------------------------------------
  // Trimmed analog reference
  // ----------------------------------------
  freq_ref_pkg::freq_type trim_amt;
  freq_ref_pkg::freq_type trimmed_ref;
  logic [freq_ref_pkg::FREQ_W:0] trim_sum;
  logic [6:0] trim_lvl;

  // Trim level clipped to 0..100 percent and scaled to 0.1 % units
  always_comb begin
    trim_lvl = i_cfg.trim_level_pct; // R15
    if (trim_lvl > freq_ref_pkg::TRIM_LEVEL_MAX) begin
      trim_lvl = freq_ref_pkg::TRIM_LEVEL_MAX; // R15
    end
    trim_amt = freq_ref_pkg::freq_type'(trim_lvl) * freq_ref_pkg::TRIM_SCALE;
  end

  // Add or subtract trim, floor at zero, cap at upper limit
  // A carry out of the sum falls back to the ceiling
  always_comb begin
    trim_sum = {1'b0, i_analog_reference_input} + {1'b0, trim_amt};
    trimmed_ref = i_analog_reference_input;
    if (trim_mode && i_ref_from_analog
        && (i_analog_reference_input != freq_ref_pkg::FREQ_ZERO)) begin // R17
      if (tinc_on && !tdec_on) begin
        trimmed_ref = trim_sum[freq_ref_pkg::FREQ_W-1:0]; // R16
        if (trim_sum[freq_ref_pkg::FREQ_W]) begin
          trimmed_ref = upper_lim;
        end
      end else if (tdec_on && !tinc_on) begin
        if (trim_amt > i_analog_reference_input) begin
          trimmed_ref = freq_ref_pkg::FREQ_ZERO; // R18
        end else begin
          trimmed_ref = i_analog_reference_input - trim_amt; // R16
        end
      end
    end
    if (trimmed_ref > upper_lim) begin
      trimmed_ref = upper_lim; // R6
    end
  end

  // ----------------------------------------
  // Held raise/lower reference
  // ----------------------------------------
  freq_ref_pkg::freq_type held_ref;
  freq_ref_pkg::freq_type start_ref;
  logic [15:0] ref_cnt;
  logic run_d;
  logic loaded;
  logic run_rise;
  logic run_fall;

  // Run command edges; the edge register idles low like the input
  assign run_rise = i_run & ~run_d;
  assign run_fall = ~i_run & run_d;

  // Starting point at a run command, bounded by the limits
  // A raise or lower held at the start ignores the saved value
  always_comb begin
    start_ref = freq_ref_pkg::FREQ_ZERO; // R21
    if (i_cfg.reference_hold_memory_select && !(up_on || dn_on)) begin
      start_ref = o_stored_ref; // R12
    end
    if (start_ref < eff_lower) begin
      start_ref = eff_lower; // R10
    end
    if (start_ref > upper_lim) begin
      start_ref = upper_lim;
    end
  end

  // Run edge tracking
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_d <= 1'b0;
    end else begin
      run_d <= i_run;
    end
  end

  // Retained copy: caught after reset, cleared or saved at run edges
  // Storage must present the saved value by the first edge after reset
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      loaded <= 1'b0;
      o_stored_ref <= freq_ref_pkg::FREQ_ZERO;
    end else if (!loaded) begin
      loaded <= 1'b1;
      o_stored_ref <= i_retained_ref; // R12
    end else if (run_rise && updown_mode && (up_on || dn_on)) begin
      o_stored_ref <= freq_ref_pkg::FREQ_ZERO; // R13
    end else if (run_fall && updown_mode) begin
      if (i_cfg.reference_hold_memory_select) begin
        o_stored_ref <= held_ref; // R12
      end else begin
        o_stored_ref <= freq_ref_pkg::FREQ_ZERO; // R21
      end
    end
  end

  // Reference steps at the ramp rate while one input is on
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      held_ref <= freq_ref_pkg::FREQ_ZERO;
      ref_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
    end else if (run_rise) begin
      held_ref <= start_ref; // R10
      ref_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
    end else if (!i_run || !updown_mode) begin
      ref_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
    end else if (held_ref < eff_lower) begin
      held_ref <= eff_lower; // R9
      ref_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
    end else if (held_ref > upper_lim) begin
      held_ref <= upper_lim; // R6
      ref_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
    end else if (up_on && !dn_on && (held_ref < upper_lim)) begin
      if (ref_cnt + freq_ref_pkg::RATE_CNT_ONE >= i_cfg.accel_step_cycles) begin
        held_ref <= held_ref + freq_ref_pkg::FREQ_STEP; // R22
        ref_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
      end else begin
        ref_cnt <= ref_cnt + freq_ref_pkg::RATE_CNT_ONE;
      end
    end else if (dn_on && !up_on && (held_ref > eff_lower)) begin
      if (ref_cnt + freq_ref_pkg::RATE_CNT_ONE >= i_cfg.decel_step_cycles) begin
        held_ref <= held_ref - freq_ref_pkg::FREQ_STEP; // R22
        ref_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
      end else begin
        ref_cnt <= ref_cnt + freq_ref_pkg::RATE_CNT_ONE;
      end
    end else begin
      ref_cnt <= freq_ref_pkg::RATE_CNT_ZERO; // R22
    end
  end

  // ----------------------------------------
  // Output ramp
  // ----------------------------------------
  freq_ref_pkg::freq_type target;
  freq_ref_pkg::ramp_state_type state;
  freq_ref_pkg::ramp_state_type next_state;
  logic [15:0] ramp_cnt;
  logic [15:0] rate;

  // Target reference selection
  // A stopped drive always heads for zero
  always_comb begin
    if (!i_run) begin
      target = freq_ref_pkg::FREQ_ZERO;
    end else if (updown_mode) begin
      target = held_ref;
    end else begin
      target = trimmed_ref;
    end
  end

  // Ramp direction
  // The step rate follows the direction about to be taken
  always_comb begin
    if (o_out_freq < target) begin
      next_state = freq_ref_pkg::st_accel;
    end else if (o_out_freq > target) begin
      next_state = freq_ref_pkg::st_decel;
    end else if (i_run) begin
      next_state = freq_ref_pkg::st_match;
    end else begin
      next_state = freq_ref_pkg::st_stop;
    end
    case (next_state)
      freq_ref_pkg::st_accel: rate = i_cfg.accel_step_cycles;
      freq_ref_pkg::st_decel: rate = i_cfg.decel_step_cycles;
      default: rate = freq_ref_pkg::RATE_CNT_ZERO;
    endcase
  end

  // Step output by one unit per rate period
  // A new direction restarts the count, so a reversal never steps at once
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= freq_ref_pkg::st_stop;
      o_out_freq <= freq_ref_pkg::FREQ_ZERO;
      ramp_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
    end else begin
      state <= next_state;
      case (next_state)
        freq_ref_pkg::st_accel,
        freq_ref_pkg::st_decel: begin
          if (state != next_state) begin
            ramp_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
          end else if (ramp_cnt + freq_ref_pkg::RATE_CNT_ONE >= rate) begin
            ramp_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
            if (next_state == freq_ref_pkg::st_accel) begin
              o_out_freq <= o_out_freq + freq_ref_pkg::FREQ_STEP; // R4
            end else begin
              o_out_freq <= o_out_freq - freq_ref_pkg::FREQ_STEP; // R4
            end
          end else begin
            ramp_cnt <= ramp_cnt + freq_ref_pkg::RATE_CNT_ONE;
          end
        end
        default: begin
          ramp_cnt <= freq_ref_pkg::RATE_CNT_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  // Match flag: running with the output settled on its target
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_freq_match <= 1'b0;
    end else begin
      o_freq_match <= i_run && (state == freq_ref_pkg::st_match); // R20
    end
  end

  // Error flag for invalid terminal assignments
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_input_config_error <= 1'b0;
    end else begin
      o_input_config_error <= next_cfg_err; // R2 R3 R19
    end
  end

  // Multi-step selection blocked while raise or lower is assigned
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_multi_step_enable <= 1'b1;
    end else begin
      o_multi_step_enable <= ~(up_asg | dn_asg); // R11
    end
  end

endmodule

// file: freq_ref_up_down_trim_monitor.sv
`timescale 1ns/100ps
module freq_ref_up_down_trim_monitor (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Design inputs
  input wire freq_ref_pkg::func_sel_type i_input_function_select,
  input wire logic [freq_ref_pkg::NUM_TERMINALS-1:0] i_multi_input_terminal,
  input wire logic i_run,
  input wire logic i_ref_from_analog,
  input wire freq_ref_pkg::freq_type i_analog_reference_input,
  input wire freq_ref_pkg::cfg_type i_cfg,
  input wire freq_ref_pkg::freq_type i_retained_ref,
  // Design outputs
  input wire freq_ref_pkg::freq_type o_stored_ref,
  input wire freq_ref_pkg::freq_type o_out_freq,
  input wire logic o_freq_match,
  input wire logic o_input_config_error,
  input wire logic o_multi_step_enable
);
  logic up, dn, hold, inc, dec, bad;
  logic [1:0] armed;
  freq_ref_pkg::freq_type cap;

  // Which functions the terminals carry
  always_comb begin
    {up, dn, hold, inc, dec} = 5'h00;
    for (int i = 0; i < freq_ref_pkg::NUM_TERMINALS; i++) begin
      up = up | (i_input_function_select[i] == freq_ref_pkg::FUNC_UP);
      dn = dn | (i_input_function_select[i] == freq_ref_pkg::FUNC_DOWN);
      hold = hold | (i_input_function_select[i] == freq_ref_pkg::FUNC_RAMP_HOLD);
      inc = inc | (i_input_function_select[i] == freq_ref_pkg::FUNC_TRIM_INC);
      dec = dec | (i_input_function_select[i] == freq_ref_pkg::FUNC_TRIM_DEC);
    end
  end

  // Invalid pairings and the effective ceiling
  assign bad = (up ^ dn) | ((up | dn) & hold) | (inc ^ dec);
  assign cap = (i_cfg.reference_upper_limit_pct > freq_ref_pkg::LIMIT_MAX) ?
    freq_ref_pkg::LIMIT_MAX : i_cfg.reference_upper_limit_pct;

  // Marks edges after reset whose past values are meaningful
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      armed <= 2'h0;
    end else begin
      armed <= {armed[0], 1'b1};
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  a_error_follows: assert property (armed[0] |-> o_input_config_error == $past(bad))
    else $error("config error flag wrong");
  a_multi_step_off: assert property (armed[0] |-> o_multi_step_enable == !$past(up | dn))
    else $error("multi-step enable wrong");
  a_out_steps: assert property (freq_ref_pkg::freq_type'(o_out_freq - $past(o_out_freq))
    inside {12'h000, 12'h001, 12'hfff}) else $error("output jumped");
  a_upper_cap: assert property (o_out_freq > $past(o_out_freq) |-> o_out_freq <= $past(cap))
    else $error("output rose above ceiling");
  a_match_needs_run: assert property (!i_run |-> ##2 !o_freq_match)
    else $error("match while stopped");
  a_stop_no_rise: assert property (!i_run && !$past(i_run) && !$past(i_run, 2)
    |-> o_out_freq <= $past(o_out_freq)) else $error("output rose while stopped");
  a_stored_steady: assert property (armed[1] && i_run == $past(i_run) && i_run == $past(i_run, 2)
    |-> $stable(o_stored_ref)) else $error("stored value moved");
  a_mem0_clears: assert property ($fell(i_run) && !i_cfg.reference_hold_memory_select && up && dn
    && !bad |-> ##[1:3] o_stored_ref == 12'h000) else $error("stored not cleared");

  // Main scenarios reached
  c_trim_match: cover property (o_freq_match && i_ref_from_analog);
  c_bad_cfg: cover property ($rose(o_input_config_error));
  c_updown_stop: cover property ($fell(i_run) && up && dn);
endmodule

// file: contact_switches.sv
`timescale 1ns/100ps
module contact_switches (
  // Clock
  input wire logic i_clk_sys,
  // Operator requests
  input wire logic [3:0] i_press,
  input wire logic i_run_req,
  // Contacts to the drive
  output logic [freq_ref_pkg::NUM_TERMINALS-1:0] o_multi_input_terminal = '0,
  output logic o_run = 1'b0
);
  // Contacts close an edge after the request; unwired terminals read open
  always @(posedge i_clk_sys) begin
    o_multi_input_terminal <= {6'h00, i_press};
    o_run <= i_run_req;
  end
endmodule

// file: freq_ref_up_down_trim_test.sv
`timescale 1ns/100ps
module freq_ref_up_down_trim_test;
  logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, run_req = 1'b0, i_ref_from_analog = 1'b0, i_run;
  logic [3:0] press = 4'h0;
  logic [9:0] i_multi_input_terminal;
  logic [1:0] e2;
  logic [11:0] exp_trim;
  logic [31:0] seed = 32'h52ad_5a54;
  logic [31:0] cases [7] = '{32'h1011_1c1d, 32'h100f_0f0f, 32'h0f11_0f0f, 32'h1011_0a0f,
    32'h0f0f_1c0f, 32'h0f0f_0f1d, 32'h0f0f_1c1d};
  int ea [$] = '{500, 0, 950, 400};
  int el [$] = '{100, 10, 10, 10};
  int fail_count = 0, cmp_count = 0, a;
  freq_ref_pkg::func_sel_type i_input_function_select = {10{8'h0f}};
  freq_ref_pkg::freq_type i_analog_reference_input = 12'h000, i_retained_ref = 12'h000;
  freq_ref_pkg::freq_type o_stored_ref, o_out_freq;
  freq_ref_pkg::cfg_type i_cfg = '{12'h3e8, 12'h000, 12'h000, 7'h0a, 1'b0, 16'h0001, 16'h0001};
  logic o_freq_match, o_input_config_error, o_multi_step_enable;

  freq_ref_up_down_trim dut (.*);
  contact_switches sw (.i_clk_sys(i_clk_sys), .i_press(press), .i_run_req(run_req),
    .o_multi_input_terminal(i_multi_input_terminal), .o_run(i_run));

  // 100 MHz clock
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference model of assignment checks: {error, multi-step enable}
  function automatic logic [1:0] cfg_model(input logic [31:0] c);
    bit u, d, h, ti, td;
    {u, d, h, ti, td} = 5'h00;
    for (int i = 0; i < 4; i++) begin
      u |= c[8*i+:8] == 8'h10;
      d |= c[8*i+:8] == 8'h11;
      h |= c[8*i+:8] == 8'h0a;
      ti |= c[8*i+:8] == 8'h1c;
      td |= c[8*i+:8] == 8'h1d;
    end
    return {(u ^ d) | ((u | d) & h) | (ti ^ td), !(u | d)};
  endfunction
  // Reference model of trimmed analog reference, ceiling 100.0 %
  function automatic logic [11:0] trim_model(input int x, input int lvl, input bit i, input bit d);
    int r;
    r = x;
    if (x > 0 && i && !d) r = x + lvl * 10;
    if (x > 0 && d && !i) r = x - lvl * 10;
    if (r < 0) r = 0;
    if (r > 1000) r = 1000;
    return r[11:0];
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Waits for match while running, or for zero output while stopped
  task automatic settle;
    int n;
    n = 0;
    step(4);
    while (!(run_req ? o_freq_match === 1'b1 : o_out_freq === 12'h000) && n < 3000) begin
      step(1);
      n++;
    end
    if (n == 3000) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic set_fsel(input logic [31:0] c);
    for (int i = 0; i < 4; i++) i_input_function_select[i] = c[31-8*i-:8];
  endtask

  // Main sequence
  initial begin
    step(6);
    i_sys_rst = 1'b0;
    step(2);
    foreach (cases[k]) begin
      set_fsel(cases[k]);
      step(2);
      e2 = cfg_model(cases[k]);
      check("config_error", {11'h000, o_input_config_error}, {11'h000, e2[1]});
      check("multi_step", {11'h000, o_multi_step_enable}, {11'h000, e2[0]});
    end
    i_ref_from_analog = 1'b1;
    run_req = 1'b1;
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      i_ref_from_analog = (k != 7);
      a = (k < 4) ? 200 + seed % 600 : ea[k-4];
      i_cfg.trim_level_pct = (k < 4) ? 7'h0a : el[k-4][6:0];
      press = (k < 4) ? k[1:0] << 2 : (k == 4 ? 4'h8 : 4'h4);
      i_analog_reference_input = a[11:0];
      settle();
      exp_trim = trim_model(a, i_cfg.trim_level_pct, press[2] & i_ref_from_analog,
        press[3] & i_ref_from_analog);
      check("trim_out", o_out_freq, exp_trim);
    end
    run_req = 1'b0;
    press = 4'h0;
    settle();
    set_fsel(32'h1011_0f0f);
    i_cfg = '{12'h12c, 12'h032, 12'h078, 7'h0a, 1'b0, 16'h0001, 16'h0002};
    i_analog_reference_input = 12'h050;
    run_req = 1'b1;
    settle();
    check("floor", o_out_freq, 12'h078);
    press = 4'h1;
    step(400);
    press = 4'h0;
    settle();
    check("raise_cap", o_out_freq, 12'h12c);
    press = 4'h3;
    step(100);
    check("both_hold", o_out_freq, 12'h12c);
    i_cfg.reference_hold_memory_select = 1'b1;
    run_req = 1'b0;
    press = 4'h0;
    settle();
    check("stored", o_stored_ref, 12'h12c);
    i_retained_ref = 12'h12c;
    i_sys_rst = 1'b1;
    step(2);
    i_sys_rst = 1'b0;
    step(2);
    run_req = 1'b1;
    settle();
    check("restart", o_out_freq, 12'h12c);
    press = 4'h2;
    step(800);
    press = 4'h0;
    settle();
    check("lower_floor", o_out_freq, 12'h078);
    i_cfg.reference_hold_memory_select = 1'b0;
    run_req = 1'b0;
    settle();
    check("stored_zero", o_stored_ref, 12'h000);
    i_cfg.reference_hold_memory_select = 1'b1;
    run_req = 1'b1;
    settle();
    check("restart_floor", o_out_freq, 12'h078);
    run_req = 1'b0;
    settle();
    check("stored_floor", o_stored_ref, 12'h078);
    press = 4'h1;
    run_req = 1'b1;
    step(5);
    press = 4'h0;
    check("stored_clear", o_stored_ref, 12'h000);
    check("match_ramp", {11'h000, o_freq_match}, 12'h000);
    give_verdict();
  end
endmodule

bind freq_ref_up_down_trim freq_ref_up_down_trim_monitor mon (.*);
